// File: drive_status_map.svh
// object indices, field positions, reset values and encodings of the drive state objects
`ifndef DRIVE_STATUS_MAP_SVH
`define DRIVE_STATUS_MAP_SVH

// object indices and subindices
`define IDX_STATE_WORD     16'h6041
`define IDX_TARGET_SPEED   16'h6042
`define IDX_SPEED_DEMAND   16'h6043
`define IDX_SPEED_ACTUAL   16'h6044
`define IDX_SPEED_LIMITS   16'h6046
`define IDX_SPEED_SOURCE   16'h320a
`define SUB_ZERO           8'h00
`define SUB_FLOOR          8'h01
`define SUB_CEILING        8'h02
`define SUB_SOURCE         8'h03
`define LIMITS_HIGHEST_SUB 32'h0000_0002

// drive state word bit positions
`define SW_READY     0
`define SW_SW_ON     1
`define SW_OP_EN     2
`define SW_FAULT     3
`define SW_VOLT      4
`define SW_QHALT_N   5
`define SW_DISABLED  6
`define SW_WARN      7
`define SW_SYNC      8
`define SW_HOST      9
`define SW_GOAL      10
`define SW_LIMIT     11
`define SW_MODE_LO   12
`define SW_CLOSED    15

// low state patterns, bits 3:0
`define PAT_IDLE       4'h0
`define PAT_READY      4'h1
`define PAT_SW_ON      4'h3
`define PAT_OP_EN      4'h7
`define PAT_FAULT_RX   4'hf
`define PAT_FAULT      4'h8

// reset values and the positive signed speed maximum
`define RST_STATE_WORD   16'h0000
`define RST_TARGET       16'h00c8
`define RST_DEMAND       16'h0000
`define RST_ACTUAL       16'h0000
`define RST_FLOOR        32'h0000_0000
`define RST_CEILING      32'hffff_ffff
`define SPEED_POS_MAX    32'h0000_7fff

`endif

// File: drive_status_pkg.sv
// types shared by the drive state and velocity limit logic
package drive_status_pkg;

   // power state machine condition reported by the control core
   typedef enum logic [2:0] {
      PS_NOT_READY,
      PS_SWITCH_ON_DISABLED,
      PS_READY,
      PS_SWITCHED_ON,
      PS_OP_ENABLED,
      PS_QUICK_HALT,
      PS_FAULT_REACTION,
      PS_FAULT
   } power_state_t;

   // same-clock inputs from the drive core
   typedef struct packed {
      power_state_t pstate;
      logic         voltage_applied;
      logic         warning;
      logic         goal_reached;
      logic [1:0]   mode_specific_bits;
      logic         setup_ok;
      logic         open_loop;
      logic [15:0]  calc_speed;
      logic [15:0]  enc_speed;
   } drive_in_t;

   // object dictionary access request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] index;
      logic [7:0]  subindex;
      logic [31:0] wdata;
   } od_req_t;

   // object dictionary answer, one cycle after the request
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } od_rsp_t;

   // whole state of the block
   typedef struct packed {
      logic        sync_ff1;
      logic        sync_ff2;
      logic        idx_ff1;
      logic        idx_ff2;
      logic        idx_seen;
      logic        src_encoder;
      logic [15:0] target;
      logic [31:0] floor_lim;
      logic [31:0] ceil_lim;
      logic [15:0] state_word;
      logic [15:0] demand;
      logic [15:0] actual;
      od_rsp_t     rsp;
   } core_state_t;

endpackage

// File: drive_status_velocity_limit.sv
// drive state word builder with velocity-mode target clamp and speed reports
// How it works
// R1 - bit 0 set when ready to switch on
// R2 - bit 1 set when switched on
// R3 - bit 2 set while operation enabled
// R4 - fault bit3, voltage bit4, warning bit7, goal bit10
// R5 - bit 5 low means quick halt
// R6 - bit 6 set when switch-on disabled
// R7 - bit 8 follows fieldbus synchronization
// R8 - bit 9 always reads one; here it reads zero in reset and until the first clock edge after
// R9 - bits 12,13 carry mode specific meaning
// R10 - bit 15 needs setup success and index seen
// R11 - idle, disabled, ready, switched-on patterns
// R12 - enabled, quick halt, fault reaction, fault patterns
// R13 - master writes signed target, resets to 00c8
// R14 - demand applied reported read-only, signed
// R15 - actual speed reported read-only, signed
// R16 - open loop picks calculated or encoder speed
// R17 - writable unsigned 32-bit floor and ceiling
// R18 - below floor use floor, set bit 11
// R19 - above ceiling use ceiling, set bit 11
// R20 - bit 11 clear when target within limits
// R21 - compare magnitude, keep sign on substitution
`timescale 1ns/1ps
`include "drive_status_map.svh"

module drive_status_velocity_limit (
   input  wire logic                      sys_clk_i,
   input  wire logic                      rst_n_i,
   input  wire drive_status_pkg::drive_in_t drv_i,
   input  wire logic                      fieldbus_sync_i,
   input  wire logic                      enc_index_i,
   input  wire drive_status_pkg::od_req_t od_req_i,
   output      drive_status_pkg::od_rsp_t od_rsp_o,
   output      logic [15:0]               state_word_o,
   output      logic [15:0]               speed_demand_o,
   output      logic [15:0]               speed_actual_o
);
   import drive_status_pkg::*;

   core_state_t st_q;
   core_state_t st_d;
   logic [16:0] tgt_ext;
   logic [16:0] tgt_mag;
   logic [31:0] mag32;
   logic        tgt_neg;
   logic        below_floor;
   logic        above_ceil;
   logic [15:0] floor16;
   logic [15:0] ceil16;
   logic [15:0] clamped;
   logic [15:0] sw_next;

   // saturate an unsigned limit into the positive signed 16-bit range
   function automatic logic [15:0] sat16(input logic [31:0] v);
      sat16 = (v > `SPEED_POS_MAX) ? 16'(`SPEED_POS_MAX) : v[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // target clamp, magnitude against unsigned limits
   assign tgt_neg     = st_q.target[15];
   assign tgt_ext     = {st_q.target[15], st_q.target};
   assign tgt_mag     = tgt_neg ? 17'(-tgt_ext) : tgt_ext;                // [R21]
   assign mag32       = {15'h0000, tgt_mag};
   assign below_floor = mag32 < st_q.floor_lim;                           // [R18]
   assign above_ceil  = !below_floor && (mag32 > st_q.ceil_lim);          // [R19]
   assign floor16     = sat16(st_q.floor_lim);
   assign ceil16      = sat16(st_q.ceil_lim);

   // floor checked first so a crossed pair of limits still gives one answer
   always_comb begin
      if (below_floor) begin
         clamped = tgt_neg ? 16'(-floor16) : floor16;                     // [R18] [R21]
      end else if (above_ceil) begin
         clamped = tgt_neg ? 16'(-ceil16) : ceil16;                       // [R19] [R21]
      end else begin
         clamped = st_q.target;                                           // [R20]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // drive state word from the power state machine
   always_comb begin
      sw_next = 16'h0000;
      case (drv_i.pstate)
         PS_NOT_READY: begin
            sw_next[3:0]       = `PAT_IDLE;                               // [R11]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
         PS_SWITCH_ON_DISABLED: begin
            sw_next[3:0]       = `PAT_IDLE;                               // [R11]
            sw_next[`SW_DISABLED] = 1'b1;                                 // [R6]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
         PS_READY: begin
            sw_next[3:0]       = `PAT_READY;                              // [R1] [R11]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
         PS_SWITCHED_ON: begin
            sw_next[3:0]       = `PAT_SW_ON;                              // [R2] [R11]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
         PS_OP_ENABLED: begin
            sw_next[3:0]       = `PAT_OP_EN;                              // [R3] [R12]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
         PS_QUICK_HALT: begin
            sw_next[3:0]       = `PAT_OP_EN;                              // [R12]
            sw_next[`SW_QHALT_N] = 1'b0;                                  // [R5]
         end
         PS_FAULT_REACTION: begin
            sw_next[3:0]       = `PAT_FAULT_RX;                           // [R12] [R4]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
         default: begin
            sw_next[3:0]       = `PAT_FAULT;                              // [R12] [R4]
            sw_next[`SW_QHALT_N] = 1'b1;
         end
      endcase
      sw_next[`SW_VOLT]  = drv_i.voltage_applied;                         // [R4]
      sw_next[`SW_WARN]  = drv_i.warning;                                 // [R4]
      sw_next[`SW_SYNC]  = st_q.sync_ff2;                                 // [R7]
      sw_next[`SW_HOST]  = 1'b1;                                          // [R8]
      sw_next[`SW_GOAL]  = drv_i.goal_reached;                            // [R4]
      sw_next[`SW_LIMIT] = below_floor || above_ceil;                     // [R18] [R19] [R20]
      sw_next[`SW_MODE_LO +: 2] = drv_i.mode_specific_bits;               // [R9]
      sw_next[`SW_CLOSED] = drv_i.setup_ok && st_q.idx_seen;              // [R10]
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state: synchronisers, reports and object access
   always_comb begin
      st_d = st_q;
      // pins cross in on two flops; only the second is looked at
      st_d.sync_ff1 = fieldbus_sync_i;
      st_d.sync_ff2 = st_q.sync_ff1;                                      // [R7]
      st_d.idx_ff1  = enc_index_i;
      st_d.idx_ff2  = st_q.idx_ff1;
      // index pulse may be one cycle wide, so remember it until reset
      if (st_q.idx_ff2) begin
         st_d.idx_seen = 1'b1;                                            // [R10]
      end
      st_d.state_word = sw_next;
      st_d.demand     = clamped;                                          // [R14]
      // encoder only overrides in closed loop or when selected
      if (drv_i.open_loop && !st_q.src_encoder) begin
         st_d.actual = drv_i.calc_speed;                                  // [R16] [R15]
      end else begin
         st_d.actual = drv_i.enc_speed;                                   // [R16] [R15]
      end
      st_d.rsp = '0;
      if (od_req_i.valid) begin
         st_d.rsp.ack = 1'b1;
         if (od_req_i.index == `IDX_STATE_WORD && od_req_i.subindex == `SUB_ZERO) begin
            st_d.rsp.rdata = {16'h0000, st_q.state_word};
            st_d.rsp.err   = od_req_i.write;
         end else if (od_req_i.index == `IDX_TARGET_SPEED && od_req_i.subindex == `SUB_ZERO) begin
            st_d.rsp.rdata = {16'h0000, st_q.target};
            if (od_req_i.write) begin
               st_d.target = od_req_i.wdata[15:0];                        // [R13]
            end
         end else if (od_req_i.index == `IDX_SPEED_DEMAND && od_req_i.subindex == `SUB_ZERO) begin
            st_d.rsp.rdata = {16'h0000, st_q.demand};                     // [R14]
            st_d.rsp.err   = od_req_i.write;
         end else if (od_req_i.index == `IDX_SPEED_ACTUAL && od_req_i.subindex == `SUB_ZERO) begin
            st_d.rsp.rdata = {16'h0000, st_q.actual};                     // [R15]
            st_d.rsp.err   = od_req_i.write;
         end else if (od_req_i.index == `IDX_SPEED_LIMITS && od_req_i.subindex == `SUB_ZERO) begin
            st_d.rsp.rdata = `LIMITS_HIGHEST_SUB;
            st_d.rsp.err   = od_req_i.write;
         end else if (od_req_i.index == `IDX_SPEED_LIMITS && od_req_i.subindex == `SUB_FLOOR) begin
            st_d.rsp.rdata = st_q.floor_lim;
            if (od_req_i.write) begin
               st_d.floor_lim = od_req_i.wdata;                           // [R17]
            end
         end else if (od_req_i.index == `IDX_SPEED_LIMITS && od_req_i.subindex == `SUB_CEILING) begin
            st_d.rsp.rdata = st_q.ceil_lim;
            if (od_req_i.write) begin
               st_d.ceil_lim = od_req_i.wdata;                            // [R17]
            end
         end else if (od_req_i.index == `IDX_SPEED_SOURCE && od_req_i.subindex == `SUB_SOURCE) begin
            st_d.rsp.rdata = {31'h0000_0000, st_q.src_encoder};
            if (od_req_i.write) begin
               st_d.src_encoder = od_req_i.wdata[0];                      // [R16]
            end
         end else begin
            // unknown object: refused, reads zero, nothing changes
            st_d.rsp.err = 1'b1;
         end
      end
   end

   // one register stage holds the whole block
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q            <= '0;
         st_q.target     <= `RST_TARGET;                                  // [R13]
         st_q.floor_lim  <= `RST_FLOOR;
         st_q.ceil_lim   <= `RST_CEILING;
         st_q.state_word <= `RST_STATE_WORD;
         st_q.demand     <= `RST_DEMAND;
         st_q.actual     <= `RST_ACTUAL;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flops
   assign od_rsp_o       = st_q.rsp;
   assign state_word_o   = st_q.state_word;
   assign speed_demand_o = st_q.demand;
   assign speed_actual_o = st_q.actual;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_sync_high;
      fieldbus_sync_i [*3];
   endsequence

   sequence s_sync_low;
      !fieldbus_sync_i [*3];
   endsequence

   sequence s_target_write;
      od_req_i.valid && od_req_i.write && od_req_i.index == `IDX_TARGET_SPEED
         && od_req_i.subindex == `SUB_ZERO;
   endsequence

   sequence s_floor_write;
      od_req_i.valid && od_req_i.write && od_req_i.index == `IDX_SPEED_LIMITS
         && od_req_i.subindex == `SUB_FLOOR;
   endsequence

   sequence s_demand_read;
      od_req_i.valid && !od_req_i.write && od_req_i.index == `IDX_SPEED_DEMAND
         && od_req_i.subindex == `SUB_ZERO;
   endsequence

   sequence s_actual_read;
      od_req_i.valid && !od_req_i.write && od_req_i.index == `IDX_SPEED_ACTUAL
         && od_req_i.subindex == `SUB_ZERO;
   endsequence

   AST_HOST_BIT: assert property ($past(rst_n_i) |-> state_word_o[`SW_HOST])   // [R8]
      else $error("host control bit not set");

   AST_OP_EN: assert property (drv_i.pstate == PS_OP_ENABLED                  // [R3]
      |=> {state_word_o[6:5], state_word_o[3:0]} == 6'h17)
      else $error("operation enabled pattern wrong");

   AST_QHALT: assert property (drv_i.pstate == PS_QUICK_HALT                  // [R5]
      |=> {state_word_o[6:5], state_word_o[3:0]} == 6'h07)
      else $error("quick halt pattern wrong");

   AST_DISABLED: assert property (drv_i.pstate == PS_SWITCH_ON_DISABLED       // [R6]
      |=> state_word_o[6] && state_word_o[3:0] == 4'h0)
      else $error("switch on disabled pattern wrong");

   AST_READY: assert property (drv_i.pstate == PS_READY                       // [R1]
      |=> state_word_o[6:5] == 2'b01 && state_word_o[3:0] == 4'h1)
      else $error("ready pattern wrong");

   AST_SW_ON: assert property (drv_i.pstate == PS_SWITCHED_ON                 // [R2]
      |=> {state_word_o[6:5], state_word_o[3:0]} == 6'h13)
      else $error("switched on pattern wrong");

   AST_NOT_READY: assert property (drv_i.pstate == PS_NOT_READY               // [R11]
      |=> !state_word_o[6] && state_word_o[3:0] == 4'h0)
      else $error("not ready pattern wrong");

   AST_FAULT_RX: assert property (drv_i.pstate == PS_FAULT_REACTION           // [R12]
      |=> !state_word_o[6] && state_word_o[3:0] == 4'hf)
      else $error("fault reaction pattern wrong");

   AST_FAULT: assert property (drv_i.pstate == PS_FAULT                       // [R12]
      |=> !state_word_o[6] && state_word_o[3:0] == 4'h8)
      else $error("fault pattern wrong");

   AST_FLAGS: assert property ($past(rst_n_i)                                 // [R4]
      |-> state_word_o[4] == $past(drv_i.voltage_applied)
      && state_word_o[7] == $past(drv_i.warning)
      && state_word_o[10] == $past(drv_i.goal_reached))
      else $error("flag bits do not follow the drive core");

   AST_MODE_BITS: assert property ($past(rst_n_i)                             // [R9]
      |-> state_word_o[13:12] == $past(drv_i.mode_specific_bits))
      else $error("mode specific bits do not follow the drive core");

   AST_SYNC_SET: assert property (s_sync_high |=> state_word_o[`SW_SYNC])    // [R7]
      else $error("sync bit not set after sync held");

   AST_SYNC_CLR: assert property (s_sync_low |=> !state_word_o[`SW_SYNC])    // [R7]
      else $error("sync bit not cleared after sync lost");

   AST_CLOSED: assert property (state_word_o[`SW_CLOSED]                      // [R10]
      |-> $past(drv_i.setup_ok) && st_q.idx_seen)
      else $error("closed loop bit without setup and index");

   AST_IDX_STICKY: assert property (st_q.idx_seen |=> st_q.idx_seen)          // [R10]
      else $error("index seen dropped before reset");

   AST_TARGET_WR: assert property (s_target_write                             // [R13]
      |=> od_rsp_o.ack && !od_rsp_o.err && st_q.target == $past(od_req_i.wdata[15:0]))
      else $error("target write not taken");

   AST_FLOOR_WR: assert property (s_floor_write                               // [R17]
      |=> od_rsp_o.ack && !od_rsp_o.err && st_q.floor_lim == $past(od_req_i.wdata))
      else $error("floor write not taken");

   AST_DEMAND_RD: assert property (s_demand_read                              // [R14]
      |=> od_rsp_o.ack && !od_rsp_o.err && od_rsp_o.rdata == {16'h0000, $past(speed_demand_o)})
      else $error("demand read wrong");

   AST_ACTUAL_RD: assert property (s_actual_read                              // [R15]
      |=> od_rsp_o.ack && !od_rsp_o.err && od_rsp_o.rdata == {16'h0000, $past(speed_actual_o)})
      else $error("actual speed read wrong");

   AST_RO_WRITE: assert property (od_req_i.valid && od_req_i.write            // [R14] [R15]
      && (od_req_i.index == `IDX_SPEED_DEMAND || od_req_i.index == `IDX_SPEED_ACTUAL)
      |=> od_rsp_o.ack && od_rsp_o.err)
      else $error("write to a read-only speed report not refused");

   AST_CLAMP_LO: assert property (below_floor && st_q.floor_lim < `SPEED_POS_MAX  // [R18]
      && $stable(st_q.target) |=> state_word_o[`SW_LIMIT]
      && speed_demand_o == ($past(tgt_neg) ? 16'(-$past(floor16)) : $past(floor16)))
      else $error("floor substitution wrong");

   AST_CLAMP_HI: assert property (above_ceil                                  // [R19]
      |=> state_word_o[`SW_LIMIT]
      && speed_demand_o == ($past(tgt_neg) ? 16'(-$past(ceil16)) : $past(ceil16)))
      else $error("ceiling substitution wrong");

   AST_IN_RANGE: assert property (!below_floor && !above_ceil                 // [R20]
      |=> !state_word_o[`SW_LIMIT] && speed_demand_o == $past(st_q.target))
      else $error("demand differs from unclamped target");

   AST_SOURCE: assert property (drv_i.open_loop && !st_q.src_encoder          // [R16]
      |=> speed_actual_o == $past(drv_i.calc_speed))
      else $error("open loop internal source not used");

   AST_ENC_SRC: assert property (!drv_i.open_loop || st_q.src_encoder         // [R16]
      |=> speed_actual_o == $past(drv_i.enc_speed))
      else $error("encoder source not used");

endmodule // drive_status_velocity_limit

// File: fieldbus_master_model.sv
// cyclic fieldbus master model issuing object dictionary requests
`timescale 1ns/1ps

module fieldbus_master_model (
   input  wire logic                      clk_i,
   output      drive_status_pkg::od_req_t req_o,
   input  wire drive_status_pkg::od_rsp_t rsp_i
);
   import drive_status_pkg::*;

   initial req_o = '0;

   ////////////////////////////////////////////////////////////////////////////
   // one request per call; valid is a single-cycle pulse, answer taken next cycle
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er, output logic ak);
      @(negedge clk_i);
      req_o = '{valid: 1'b1, write: wr, index: idx, subindex: sub, wdata: wd};
      @(negedge clk_i);
      ak = rsp_i.ack;
      er = rsp_i.err;
      rd = rsp_i.rdata;
      // released fields carry the inverse so stale values never look live
      req_o = '{valid: 1'b0, write: ~wr, index: ~idx, subindex: ~sub, wdata: ~wd};
   endtask
endmodule // fieldbus_master_model

// File: test_drive_status_velocity_limit.sv
// self-checking bench for the drive state word and velocity limit block
`timescale 1ns/1ps
`include "drive_status_map.svh"

module test_drive_status_velocity_limit;
   import drive_status_pkg::*;

   logic        sys_clk_i;
   logic        rst_n_i;
   logic        fieldbus_sync_i;
   logic        enc_index_i;
   drive_in_t   drv_i;
   od_req_t     od_req_i;
   od_rsp_t     od_rsp_o;
   logic [15:0] state_word_o;
   logic [15:0] speed_demand_o;
   logic [15:0] speed_actual_o;
   logic [31:0] rd;
   logic        er;
   logic        ak;
   int          err_count;
   int          n_compared;

   // low state patterns, state word bits 6:0 per power state, and cared bits
   localparam logic [6:0] PS_VAL [8] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08};
   localparam logic [6:0] PS_MSK [8] = '{7'h5f, 7'h5f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h5f, 7'h5f};

   drive_status_velocity_limit uut (
      .sys_clk_i      (sys_clk_i),
      .rst_n_i        (rst_n_i),
      .drv_i          (drv_i),
      .fieldbus_sync_i(fieldbus_sync_i),
      .enc_index_i    (enc_index_i),
      .od_req_i       (od_req_i),
      .od_rsp_o       (od_rsp_o),
      .state_word_o   (state_word_o),
      .speed_demand_o (speed_demand_o),
      .speed_actual_o (speed_actual_o)
   );

   fieldbus_master_model master (
      .clk_i(sys_clk_i),
      .req_o(od_req_i),
      .rsp_i(od_rsp_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask

   // one access, answer must come with the expected error flag
   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, input logic exp_err);
      master.xfer(wr, idx, sub, wd, rd, er, ak);
      chk(32'(ak), 32'h1, "ack");
      chk(32'(er), 32'(exp_err), "err");
   endtask

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset_values();
      acc(1'b0, `IDX_TARGET_SPEED, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_00c8, "target reset");
      acc(1'b0, `IDX_SPEED_DEMAND, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_00c8, "demand after reset");
      acc(1'b0, `IDX_SPEED_LIMITS, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_0002, "highest sub");
      acc(1'b0, `IDX_SPEED_LIMITS, `SUB_FLOOR, 32'h0, 1'b0);
      chk(rd, 32'h0, "floor reset");
   endtask

   task automatic test_power_states();
      for (int i = 0; i < 8; i++) begin
         drv_i.pstate = power_state_t'(i[2:0]);
         step(1);
         chk(32'(state_word_o[6:0] & PS_MSK[i]), 32'(PS_VAL[i]), "state bits");
         chk(32'(state_word_o[9]), 32'h1, "host bit");
      end
      acc(1'b0, `IDX_STATE_WORD, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_0228, "state word read");
   endtask

   task automatic test_flags();
      drv_i.voltage_applied = 1'b1;
      drv_i.warning = 1'b1;
      drv_i.goal_reached = 1'b1;
      drv_i.mode_specific_bits = 2'b10;
      step(1);
      chk(32'({state_word_o[13:12], state_word_o[10], state_word_o[7], state_word_o[4]}),
          32'h17, "flags set");
      drv_i.voltage_applied = 1'b0;
      drv_i.goal_reached = 1'b0;
      drv_i.mode_specific_bits = 2'b01;
      step(1);
      chk(32'({state_word_o[13:12], state_word_o[10], state_word_o[7], state_word_o[4]}),
          32'h0a, "flags mixed");
   endtask

   task automatic test_sync_and_loop();
      fieldbus_sync_i = 1'b1;
      step(2);
      chk(32'(state_word_o[8]), 32'h0, "sync early");
      step(1);
      chk(32'(state_word_o[8]), 32'h1, "sync set");
      fieldbus_sync_i = 1'b0;
      drv_i.setup_ok = 1'b1;
      step(6);
      chk(32'(state_word_o[8]), 32'h0, "sync lost");
      chk(32'(state_word_o[15]), 32'h0, "no index yet");
      enc_index_i = 1'b1;
      step(2);
      enc_index_i = 1'b0;
      step(4);
      chk(32'(state_word_o[15]), 32'h1, "closed loop");
      drv_i.setup_ok = 1'b0;
      step(2);
      chk(32'(state_word_o[15]), 32'h0, "setup lost");
   endtask

   // floor 0x64, ceiling 0x3e8; magnitude compared, sign kept on substitution
   task automatic test_clamp();
      logic [15:0] tgt [7];
      logic [15:0] dem [7];
      logic        lim [7];
      logic [15:0] prev;
      tgt = '{16'h0050, 16'hffb0, 16'h0500, 16'hfb00, 16'h0200, 16'h0064, 16'h03e8};
      dem = '{16'h0064, 16'hff9c, 16'h03e8, 16'hfc18, 16'h0200, 16'h0064, 16'h03e8};
      lim = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      prev = 16'h00c8;
      acc(1'b1, `IDX_SPEED_LIMITS, `SUB_FLOOR, 32'h0000_0064, 1'b0);
      acc(1'b1, `IDX_SPEED_LIMITS, `SUB_CEILING, 32'h0000_03e8, 1'b0);
      acc(1'b0, `IDX_SPEED_LIMITS, `SUB_CEILING, 32'h0, 1'b0);
      chk(rd, 32'h0000_03e8, "ceiling readback");
      for (int i = 0; i < 7; i++) begin
         acc(1'b1, `IDX_TARGET_SPEED, `SUB_ZERO, {16'h0, tgt[i]}, 1'b0);
         chk(rd, {16'h0, prev}, "old target");
         prev = tgt[i];
         step(1);
         chk(32'(speed_demand_o), 32'(dem[i]), "demand");
         chk(32'(state_word_o[11]), 32'(lim[i]), "limit flag");
      end
      acc(1'b0, `IDX_SPEED_DEMAND, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_03e8, "demand read");
   endtask

   task automatic test_refused();
      logic [15:0] ix [4];
      logic [7:0]  sb [4];
      ix = '{`IDX_STATE_WORD, `IDX_SPEED_DEMAND, `IDX_SPEED_ACTUAL, `IDX_SPEED_LIMITS};
      sb = '{`SUB_ZERO, `SUB_ZERO, `SUB_ZERO, `SUB_ZERO};
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, ix[i], sb[i], 32'h0000_5a5a, 1'b1);
      end
      acc(1'b0, `IDX_SPEED_DEMAND, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_03e8, "demand kept");
      acc(1'b0, 16'h1234, 8'h07, 32'h0, 1'b1);
      chk(rd, 32'h0, "unknown read data");
   endtask

   task automatic test_actual();
      drv_i.calc_speed = 16'h0111;
      drv_i.enc_speed = 16'hf222;
      drv_i.open_loop = 1'b1;
      step(2);
      chk(32'(speed_actual_o), 32'h0000_0111, "internal source");
      acc(1'b1, `IDX_SPEED_SOURCE, `SUB_SOURCE, 32'h1, 1'b0);
      step(2);
      chk(32'(speed_actual_o), 32'h0000_f222, "encoder source");
      acc(1'b0, `IDX_SPEED_ACTUAL, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_f222, "actual read");
   endtask

   // reset in mid-run must forget the index, the speed source selection and the written target
   task automatic test_mid_reset();
      drv_i.setup_ok = 1'b1;
      rst_n_i = 1'b0;
      step(2);
      chk(32'(state_word_o), 32'h0, "state word in mid-run reset");
      rst_n_i = 1'b1;
      step(2);
      chk(32'(state_word_o[15]), 32'h0, "index forgotten");
      chk(32'(speed_actual_o), 32'h0000_0111, "source back to internal");
      acc(1'b0, `IDX_TARGET_SPEED, `SUB_ZERO, 32'h0, 1'b0);
      chk(rd, 32'h0000_00c8, "target after mid-run reset");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      err_count = 0;
      n_compared = 0;
      rst_n_i = 1'b0;
      fieldbus_sync_i = 1'b0;
      enc_index_i = 1'b0;
      drv_i = '0;
      repeat (6) @(negedge sys_clk_i);
      chk(32'(state_word_o), 32'h0, "state word in reset");
      rst_n_i = 1'b1;
      test_reset_values();
      test_power_states();
      test_flags();
      test_sync_and_loop();
      test_clamp();
      test_refused();
      test_actual();
      test_mid_reset();
      test_done();
   end

   // the sequence needs about a hundred cycles; a hang is cut well beyond that
   initial begin
      repeat (4000) @(posedge sys_clk_i);
      err_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      test_done();
   end
endmodule // test_drive_status_velocity_limit
